/* pkg/oma_pkg.sv */
// constants and types for the operating-mode arbiter
// Summary of operation
// - mode changes only on selector move or remote request
// - run position gives Run mode, no edits
// - run position refuses edit, download, firmware update
// - run or program position ignores remote requests
// - run to remote enters Remote Run
// - program to remote enters Remote Program
// - Remote Test only by remote request at remote
// - Remote Run adds edits and remote changes
// - Remote Program adds remote mode changes
// - Remote Test runs tasks, outputs take program-state values, no download
// - non-logic outputs take configured on, off or hold
// - Program mode: no tasks, no message initiation (replies and tags stay on), download allowed
// - only centre position allows remote mode choice
package oma_pkg;
	// selector positions as sampled from the switch
	typedef enum logic [1:0] {
		SEL_RUN = 2'h0,
		SEL_REMOTE = 2'h1,
		SEL_PROGRAM = 2'h2,
		SEL_NONE = 2'h3
	} oma_sel_t;
	// remote request codes
	localparam logic [1:0] REQ_REM_PROGRAM = 2'h0;
	localparam logic [1:0] REQ_REM_RUN = 2'h1;
	localparam logic [1:0] REQ_REM_TEST = 2'h2;
	// program-state output choices per output bit
	localparam logic [1:0] OUT_OFF = 2'h0;
	localparam logic [1:0] OUT_ON = 2'h1;
	localparam logic [1:0] OUT_HOLD = 2'h2;
	// operating modes
	typedef enum logic [2:0] {
		MODE_RUN,
		MODE_REM_RUN,
		MODE_REM_TEST,
		MODE_REM_PROGRAM,
		MODE_PROGRAM
	} oma_mode_t;
	// reset values
	localparam logic [2:0] SYNC_RESET = 3'h0;
endpackage

/* src/oma_out_stage.sv */
// output stage: logic-driven or configured program-state value per output
`timescale 1ns/1ps
`default_nettype none
module oma_out_stage #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic logicControl,
	input wire logic [WIDTH-1:0] logicOut,
	input wire logic [2*WIDTH-1:0] progStateCfg,
	// result
	output logic [WIDTH-1:0] outputs
);
	typedef struct packed {
		logic [WIDTH-1:0] outVal;
	} oma_os_t;
	oma_os_t state_reg;
	oma_os_t state_next;

	// each bit chooses logic value or its own program-state choice
	always_comb begin
		state_next = state_reg;
		for (int i = 0; i < WIDTH; i++) begin
			if (logicControl) begin
				state_next.outVal[i] = logicOut[i];
			end else if (progStateCfg[2*i +: 2] == oma_pkg::OUT_ON) begin
				state_next.outVal[i] = 1'b1;
			end else if (progStateCfg[2*i +: 2] == oma_pkg::OUT_OFF) begin
				state_next.outVal[i] = 1'b0;
			end else begin
				state_next.outVal[i] = state_reg.outVal[i]; // hold last value
			end
		end
	end

	// register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign outputs = state_reg.outVal;

	a_forced_on: assert property (@(posedge clk) disable iff (rst)
		(!logicControl && progStateCfg[1:0] == oma_pkg::OUT_ON) |=> outputs[0])
		else $error("forced-on output not high");
	a_hold_last: assert property (@(posedge clk) disable iff (rst)
		(!logicControl && progStateCfg[1:0] == oma_pkg::OUT_HOLD) |=> $stable(outputs[0]))
		else $error("held output changed");
endmodule
`default_nettype wire

/* src/oma_arbiter.sv */
// operating-mode arbiter: selector, remote requests and permissions
`timescale 1ns/1ps
`default_nettype none
module oma_arbiter #(
	parameter int OUT_WIDTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// mode switch pins, one-hot-ish, asynchronous
	input wire logic selectorRunPosition,
	input wire logic selectorRemotePosition,
	input wire logic selectorProgramPosition,
	// remote tool request, same clock
	input wire logic remoteReqValid,
	input wire logic [1:0] remoteReqMode,
	// remote tool answer
	output logic remoteReqAccepted,
	output logic remoteReqRejected,
	// requests checked against the mode
	input wire logic editReq,
	input wire logic downloadReq,
	input wire logic firmwareReq,
	output logic editGranted,
	output logic downloadGranted,
	output logic firmwareGranted,
	// output data path
	input wire logic [OUT_WIDTH-1:0] logicOut,
	input wire logic [2*OUT_WIDTH-1:0] progStateCfg,
	output logic [OUT_WIDTH-1:0] moduleOutputs,
	// permissions and mode
	output logic [2:0] opMode,
	output logic taskExecEnable,
	output logic outputControlEnable,
	output logic onlineEditEnable,
	output logic downloadEnable,
	output logic remoteChangeEnable,
	output logic messageInitEnable,
	output logic tagExchangeEnable,
	output logic messageReplyEnable
);
	typedef struct packed {
		logic [2:0] syncRun;
		logic [2:0] syncRem;
		logic [2:0] syncProg;
		oma_pkg::oma_sel_t selPrev;
		logic started;
		oma_pkg::oma_mode_t mode;
		logic accepted;
		logic rejected;
		logic editG;
		logic downloadG;
		logic firmwareG;
	} oma_state_t;
	oma_state_t state_reg;
	oma_state_t state_next;

	oma_pkg::oma_sel_t selNow;
	logic remoteAllowed;

	// stable position after two synchroniser stages; bit 1 is the safe one
	always_comb begin
		if (state_reg.syncRun[1]) begin
			selNow = oma_pkg::SEL_RUN;
		end else if (state_reg.syncProg[1]) begin
			selNow = oma_pkg::SEL_PROGRAM;
		end else if (state_reg.syncRem[1]) begin
			selNow = oma_pkg::SEL_REMOTE;
		end else begin
			selNow = oma_pkg::SEL_NONE; // between detents: keep mode
		end
	end

	// remote changes only in the remote modes, i.e. centre position
	assign remoteAllowed = (state_reg.mode == oma_pkg::MODE_REM_RUN) ||
		(state_reg.mode == oma_pkg::MODE_REM_TEST) ||
		(state_reg.mode == oma_pkg::MODE_REM_PROGRAM);

	// next-state: synchronise, follow selector, arbitrate remote requests
	always_comb begin
		state_next = state_reg;
		state_next.syncRun = {state_reg.syncRun[1:0], selectorRunPosition};
		state_next.syncRem = {state_reg.syncRem[1:0], selectorRemotePosition};
		state_next.syncProg = {state_reg.syncProg[1:0], selectorProgramPosition};
		state_next.accepted = 1'b0;
		state_next.rejected = 1'b0;
		if (selNow != oma_pkg::SEL_NONE) begin
			state_next.selPrev = selNow;
		end
		if (!state_reg.started) begin
			// first settled sample after reset picks the mode
			if (selNow != oma_pkg::SEL_NONE) begin
				state_next.started = 1'b1;
				unique case (selNow)
					oma_pkg::SEL_RUN: state_next.mode = oma_pkg::MODE_RUN;
					oma_pkg::SEL_PROGRAM: state_next.mode = oma_pkg::MODE_PROGRAM;
					default: state_next.mode = oma_pkg::MODE_REM_PROGRAM;
				endcase
			end
		end else if (selNow != oma_pkg::SEL_NONE && selNow != state_reg.selPrev) begin
			// selector movement wins over a remote request in the same cycle
			unique case (selNow)
				oma_pkg::SEL_RUN: state_next.mode = oma_pkg::MODE_RUN;
				oma_pkg::SEL_PROGRAM: state_next.mode = oma_pkg::MODE_PROGRAM;
				default: begin
					if (state_reg.selPrev == oma_pkg::SEL_RUN) begin
						state_next.mode = oma_pkg::MODE_REM_RUN;
					end else begin
						state_next.mode = oma_pkg::MODE_REM_PROGRAM;
					end
				end
			endcase
			state_next.rejected = remoteReqValid;
		end else if (remoteReqValid) begin
			if (remoteAllowed && selNow == oma_pkg::SEL_REMOTE) begin
				state_next.accepted = 1'b1;
				case (remoteReqMode)
					oma_pkg::REQ_REM_RUN: state_next.mode = oma_pkg::MODE_REM_RUN;
					oma_pkg::REQ_REM_TEST: state_next.mode = oma_pkg::MODE_REM_TEST;
					oma_pkg::REQ_REM_PROGRAM: state_next.mode = oma_pkg::MODE_REM_PROGRAM;
					default: begin
						state_next.accepted = 1'b0;
						state_next.rejected = 1'b1; // unknown code
					end
				endcase
			end else begin
				state_next.rejected = 1'b1;
			end
		end
		// grants follow the mode in force when the request is seen
		state_next.editG = editReq && (state_reg.mode != oma_pkg::MODE_RUN) &&
			state_reg.started;
		state_next.downloadG = downloadReq && state_reg.started &&
			((state_reg.mode == oma_pkg::MODE_PROGRAM) ||
			(state_reg.mode == oma_pkg::MODE_REM_PROGRAM));
		state_next.firmwareG = firmwareReq && state_reg.started &&
			(selNow != oma_pkg::SEL_RUN) && (state_reg.mode != oma_pkg::MODE_RUN);
	end

	// register the whole state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '{syncRun: oma_pkg::SYNC_RESET, syncRem: oma_pkg::SYNC_RESET,
				syncProg: oma_pkg::SYNC_RESET, selPrev: oma_pkg::SEL_NONE, started: 1'b0,
				mode: oma_pkg::MODE_PROGRAM, accepted: 1'b0, rejected: 1'b0,
				editG: 1'b0, downloadG: 1'b0, firmwareG: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	// permission decode; until the first sample the block stays passive
	always_comb begin
		taskExecEnable = 1'b0;
		outputControlEnable = 1'b0;
		onlineEditEnable = 1'b0;
		downloadEnable = 1'b0;
		remoteChangeEnable = 1'b0;
		messageInitEnable = 1'b0;
		tagExchangeEnable = state_reg.started;
		messageReplyEnable = state_reg.started;
		if (state_reg.started) begin
			unique case (state_reg.mode)
				oma_pkg::MODE_RUN: begin
					taskExecEnable = 1'b1;
					outputControlEnable = 1'b1;
					messageInitEnable = 1'b1;
				end
				oma_pkg::MODE_REM_RUN: begin
					taskExecEnable = 1'b1;
					outputControlEnable = 1'b1;
					messageInitEnable = 1'b1;
					onlineEditEnable = 1'b1;
					remoteChangeEnable = 1'b1;
				end
				oma_pkg::MODE_REM_TEST: begin
					taskExecEnable = 1'b1;
					messageInitEnable = 1'b1;
					onlineEditEnable = 1'b1;
					remoteChangeEnable = 1'b1;
				end
				oma_pkg::MODE_REM_PROGRAM: begin
					downloadEnable = 1'b1;
					onlineEditEnable = 1'b1;
					remoteChangeEnable = 1'b1;
				end
				oma_pkg::MODE_PROGRAM: begin
					downloadEnable = 1'b1;
					onlineEditEnable = 1'b1;
				end
			endcase
		end
	end

	assign opMode = state_reg.mode;
	assign remoteReqAccepted = state_reg.accepted;
	assign remoteReqRejected = state_reg.rejected;
	assign editGranted = state_reg.editG;
	assign downloadGranted = state_reg.downloadG;
	assign firmwareGranted = state_reg.firmwareG;

	// outputs leave logic control whenever the mode does not drive them
	oma_out_stage #(
		.WIDTH(OUT_WIDTH)
	) u_out (
		.clk(clk),
		.rst(rst),
		.logicControl(outputControlEnable),
		.logicOut(logicOut),
		.progStateCfg(progStateCfg),
		.outputs(moduleOutputs)
	);

	a_run_no_edit: assert property (@(posedge clk) disable iff (rst)
		(state_reg.mode == oma_pkg::MODE_RUN && editReq) |=> !editGranted)
		else $error("edit granted in Run mode");
	a_remote_ignored: assert property (@(posedge clk) disable iff (rst)
		(remoteReqValid && selNow != oma_pkg::SEL_REMOTE) |=> !remoteReqAccepted)
		else $error("remote request accepted off centre");
	a_run_to_rem: assert property (@(posedge clk) disable iff (rst)
		(state_reg.started && state_reg.selPrev == oma_pkg::SEL_RUN &&
		selNow == oma_pkg::SEL_REMOTE) |=> opMode == oma_pkg::MODE_REM_RUN)
		else $error("run to remote did not give Remote Run");
	a_selector_program_position_to_rem: assert property (@(posedge clk) disable iff (rst)
		(state_reg.started && state_reg.selPrev == oma_pkg::SEL_PROGRAM &&
		selNow == oma_pkg::SEL_REMOTE) |=> opMode == oma_pkg::MODE_REM_PROGRAM)
		else $error("program to remote did not give Remote Program");
	a_test_by_req: assert property (@(posedge clk) disable iff (rst)
		(opMode != oma_pkg::MODE_REM_TEST) ##1 (opMode == oma_pkg::MODE_REM_TEST) |->
		$past(remoteReqValid) && $past(remoteReqMode) == oma_pkg::REQ_REM_TEST)
		else $error("Remote Test entered without request");
	a_test_outputs: assert property (@(posedge clk) disable iff (rst)
		opMode == oma_pkg::MODE_REM_TEST |-> taskExecEnable && !outputControlEnable
		&& !downloadEnable)
		else $error("Remote Test permissions wrong");
	a_selector_program_position_no_task: assert property (@(posedge clk) disable iff (rst)
		(state_reg.started && opMode == oma_pkg::MODE_PROGRAM) |->
		!taskExecEnable && !messageInitEnable && downloadEnable)
		else $error("Program mode permissions wrong");
	a_run_perm: assert property (@(posedge clk) disable iff (rst)
		(state_reg.started && opMode == oma_pkg::MODE_RUN) |->
		outputControlEnable && !onlineEditEnable && !remoteChangeEnable)
		else $error("Run mode permissions wrong");
	a_remrun_perm: assert property (@(posedge clk) disable iff (rst)
		(state_reg.started && opMode == oma_pkg::MODE_REM_RUN) |->
		onlineEditEnable && remoteChangeEnable && !downloadEnable)
		else $error("Remote Run permissions wrong");
	a_remprog_perm: assert property (@(posedge clk) disable iff (rst)
		(state_reg.started && opMode == oma_pkg::MODE_REM_PROGRAM) |->
		remoteChangeEnable && downloadEnable && !taskExecEnable)
		else $error("Remote Program permissions wrong");
	a_stable_mode: assert property (@(posedge clk) disable iff (rst)
		(state_reg.started && !remoteReqValid && selNow == state_reg.selPrev) |=>
		$stable(opMode))
		else $error("mode changed with no cause");
	a_reset_remote: assert property (@(posedge clk) disable iff (rst)
		(!state_reg.started && selNow == oma_pkg::SEL_REMOTE) |=>
		opMode == oma_pkg::MODE_REM_PROGRAM)
		else $error("remote at reset did not give Remote Program");
endmodule
`default_nettype wire

/* testbench/oma_switch_model.sv */
// front-panel mode switch model with break-before-make contacts
`timescale 1ns/1ps
`default_nettype none
module oma_switch_model (
	// clock for pacing the contact movement
	input wire logic clk,
	// position commanded by the bench
	input wire logic [1:0] position,
	// switch contacts
	output logic runPin,
	output logic remotePin,
	output logic programPin
);
	logic [1:0] shownPos = 2'h3;
	int transit;
	// all contacts open while between detents, for a random number of cycles
	initial begin
		{runPin, remotePin, programPin} = 3'h0;
		forever begin
			@(posedge clk);
			#1;
			if (position != shownPos) begin
				{runPin, remotePin, programPin} = 3'h0;
				transit = 1 + $urandom_range(2);
				repeat (transit) @(posedge clk);
				#1;
				shownPos = position;
				runPin = (position == oma_pkg::SEL_RUN);
				remotePin = (position == oma_pkg::SEL_REMOTE);
				programPin = (position == oma_pkg::SEL_PROGRAM);
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/tb_operating_mode_arbiter.sv */
// self-checking bench for the operating-mode arbiter
`timescale 1ns/1ps
`default_nettype none
module tb_operating_mode_arbiter;
	localparam logic [2:0] M_RUN = oma_pkg::MODE_RUN;
	localparam logic [2:0] M_RRUN = oma_pkg::MODE_REM_RUN;
	localparam logic [2:0] M_RTEST = oma_pkg::MODE_REM_TEST;
	localparam logic [2:0] M_RPROG = oma_pkg::MODE_REM_PROGRAM;
	localparam logic [2:0] M_SELECTOR_PROGRAM_POSITION = oma_pkg::MODE_PROGRAM;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] position = oma_pkg::SEL_REMOTE;
	logic runPin, remotePin, programPin, accepted, rejected;
	logic editGranted, downloadGranted, firmwareGranted;
	logic reqValid = 1'b0;
	logic [1:0] reqMode = 2'h0;
	logic [7:0] logicOut = 8'h00;
	logic [15:0] cfg = 16'h0000;
	logic [7:0] modOut, lastOut;
	// eight separate outputs land in one word, so it must be a net
	wire [7:0] perms;
	logic [2:0] permReq = 3'h7;
	logic [2:0] opMode;
	logic [3:0] notes[$];
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;

	initial forever #2.5 clk = ~clk;

	oma_switch_model sw_u (.clk(clk), .position(position), .runPin(runPin),
		.remotePin(remotePin), .programPin(programPin));
	oma_arbiter #(.OUT_WIDTH(8)) dut_u (.clk(clk), .rst(rst),
		.selectorRunPosition(runPin), .selectorRemotePosition(remotePin),
		.selectorProgramPosition(programPin), .remoteReqValid(reqValid),
		.remoteReqMode(reqMode), .remoteReqAccepted(accepted), .remoteReqRejected(rejected),
		.editReq(permReq[2]), .downloadReq(permReq[1]), .firmwareReq(permReq[0]),
		.editGranted(editGranted), .downloadGranted(downloadGranted),
		.firmwareGranted(firmwareGranted), .logicOut(logicOut), .progStateCfg(cfg),
		.moduleOutputs(modOut), .opMode(opMode), .taskExecEnable(perms[7]),
		.outputControlEnable(perms[6]), .onlineEditEnable(perms[5]),
		.downloadEnable(perms[4]), .remoteChangeEnable(perms[3]),
		.messageInitEnable(perms[2]), .tagExchangeEnable(perms[1]),
		.messageReplyEnable(perms[0]));

	// task, output, edit, download, remote change, message, tags, reply
	function automatic logic [7:0] permOf(input logic [2:0] m);
		case (m)
			M_RUN: permOf = 8'hc7;
			M_RRUN: permOf = 8'hef;
			M_RTEST: permOf = 8'haf;
			M_RPROG: permOf = 8'h3b;
			default: permOf = 8'h33;
		endcase
	endfunction

	// forced bits take on or off, hold codes keep the last driven value
	function automatic logic [7:0] heldOut(input logic [7:0] last, input logic [15:0] c);
		for (int i = 0; i < 8; i++)
			heldOut[i] = (c[2*i+:2] == oma_pkg::OUT_ON) | (c[2*i+1] & last[i]);
	endfunction

	task automatic count(input logic ok, input string what);
		num_checks++;
		if (!ok) begin
			mismatches++;
			$display("[ERR] %0t %s mismatch", $time, what);
		end
	endtask

	task automatic checkState(input logic [2:0] m);
		count({opMode, perms} === {m, permOf(m)}, "mode or permissions");
		count({editGranted, downloadGranted, firmwareGranted} ===
			({2'(permOf(m) >> 4), m != M_RUN} & permReq), "grants");
	endtask

	task automatic checkAnswer(input logic [3:0] n);
		count({accepted, rejected, opMode} === {n[3], !n[3], n[2:0]}, "request answer");
	endtask

	task automatic checkOut(input logic [7:0] e);
		count(modOut === e, "module outputs");
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// explicit tool request; valid stays up so calls may run back to back
	task automatic req(input logic [1:0] code, input logic acc, input logic [2:0] m);
		notes.push_back({acc, m});
		reqValid = 1'b1;
		reqMode = code;
		tick(1);
	endtask

	task automatic idle();
		reqValid = 1'b0;
		tick(3);
	endtask

	// the switch needs transit plus synchroniser time before the mode follows
	task automatic move(input logic [1:0] p, input logic [2:0] m);
		position = p;
		tick(10);
		checkState(m);
	endtask

	task automatic doReset(input logic [1:0] p, input logic [2:0] m);
		position = p;
		tick(10);
		rst = 1'b1;
		tick(2);
		count(perms === 8'h00, "permissions in reset");
		rst = 1'b0;
		tick(6);
		checkState(m);
	endtask

	// each answer pulse takes the oldest outstanding note
	always @(negedge clk) begin
		if (accepted === 1'b1 || rejected === 1'b1) begin
			if (notes.size() == 0)
				count(1'b0, "unexpected answer");
			else
				checkAnswer(notes.pop_front());
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			$display("[ERR] %0t timeout", $time);
			end_of_test();
		end
	end

	initial begin
		void'($urandom(89418));
		tick(16);
		rst = 1'b0;
		tick(6);
		checkState(M_RPROG);
		doReset(oma_pkg::SEL_PROGRAM, M_SELECTOR_PROGRAM_POSITION);
		req(oma_pkg::REQ_REM_RUN, 1'b0, M_SELECTOR_PROGRAM_POSITION);
		idle();
		doReset(oma_pkg::SEL_RUN, M_RUN);
		req(oma_pkg::REQ_REM_TEST, 1'b0, M_RUN);
		idle();
		doReset(oma_pkg::SEL_REMOTE, M_RPROG);
		$display("test reset and refusals done");
		req(oma_pkg::REQ_REM_RUN, 1'b1, M_RRUN);
		req(oma_pkg::REQ_REM_TEST, 1'b1, M_RTEST);
		idle();
		checkState(M_RTEST);
		req(2'h3, 1'b0, M_RTEST);
		req(oma_pkg::REQ_REM_PROGRAM, 1'b1, M_RPROG);
		idle();
		checkState(M_RPROG);
		$display("test remote requests done");
		move(oma_pkg::SEL_PROGRAM, M_SELECTOR_PROGRAM_POSITION);
		move(oma_pkg::SEL_REMOTE, M_RPROG);
		move(oma_pkg::SEL_RUN, M_RUN);
		move(oma_pkg::SEL_REMOTE, M_RRUN);
		tick(20);
		checkState(M_RRUN);
		$display("test selector moves done");
		for (int r = 0; r < 4; r++) begin
			req(oma_pkg::REQ_REM_RUN, 1'b1, M_RRUN);
			idle();
			lastOut = 8'($urandom);
			logicOut = lastOut;
			tick(3);
			checkOut(lastOut);
			cfg = 16'($urandom);
			req(oma_pkg::REQ_REM_TEST, 1'b1, M_RTEST);
			idle();
			checkOut(heldOut(lastOut, cfg));
			logicOut = 8'($urandom);
			tick(3);
			checkOut(heldOut(lastOut, cfg));
		end
		permReq = 3'($urandom);
		tick(2);
		checkState(M_RTEST);
		permReq = 3'h0;
		tick(2);
		checkState(M_RTEST);
		$display("test output states done");
		count(notes.size() == 0, "missing answers");
		end_of_test();
	end
endmodule
`default_nettype wire
